/* File: hdl/asf_adder.sv */
// Purpose: 8-bit adder giving half, full carry and signed overflow.
// Assumes: Purely combinational.
// Notes: Subtraction is fed the complemented operand with carry in set.
`timescale 1ns/1ns
`default_nettype none
module asf_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  output logic [WIDTH-1:0] sum,
  output logic half,
  output logic carry,
  output logic ovf
);
  logic [4:0] lo;
  logic [WIDTH:0] full;
  if (WIDTH != 8) begin : g_width_check
    $error("asf_adder serves 8 bits only");
  end
  always_comb begin
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    sum = full[WIDTH-1:0];
    half = lo[4];
    carry = full[WIDTH];
    ovf = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
  end
endmodule
`default_nettype wire

/* File: hdl/asf_consts.svh */
// Purpose: Offsets, field positions and reset values of the arithmetic status block.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH
`define ASF_STATUS_OFS 8'h04
`define ASF_INSTR_OFS 8'h08
`define ASF_OPER_OFS 8'h09
`define ASF_RESULT_OFS 8'h0a
`define ASF_WORKING_REGISTER_OFS 8'h0b
`define ASF_FILE_OFS 8'h0c
`define ASF_PTR0_OFS 8'h0d
`define ASF_PTR1_OFS 8'h0e
`define ASF_CARRY_BIT 0
`define ASF_HALF_BIT 1
`define ASF_ZERO_BIT 2
`define ASF_OVF_BIT 3
`define ASF_STATUS_RST 8'h00
`define ASF_MODE_DEC 2'h0
`define ASF_MODE_INC 2'h1
`endif

/* File: hdl/asf_core.sv */
// Purpose: Arithmetic status register, flag generation and pointer update modes.
// Assumes: One instruction per write to the instruction register.
// Notes: Registers reached over a plain strobe port, read data one cycle later.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "asf_consts.svh"
module asf_core (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic [7:0] arith_status_register,
  output logic [7:0] indirect_pointer_zero,
  output logic [7:0] indirect_pointer_one
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] instr;
    logic [7:0] oper;
    logic [7:0] result;
    logic [7:0] working_register;
    logic [7:0] file;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] rdata;
  } asf_state_s;

  asf_state_s st_q;
  asf_state_s st_d;
  asf_pkg::asf_instr_s ins;
  logic [7:0] src_a;
  logic [7:0] src_b;
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] sum;
  logic half;
  logic carry;
  logic ovf;

  function automatic logic [7:0] ptr_step(input logic [7:0] p, input logic [1:0] mode);
    logic [7:0] r;
    r = p;
    if (mode == `ASF_MODE_DEC) begin
      r = p - 8'h01;
    end else if (mode == `ASF_MODE_INC) begin
      r = p + 8'h01;
    end
    return r;
  endfunction

  // Bit 1 of the instruction word carries nothing, so it is left out of the decode.
  assign ins = asf_pkg::asf_instr_s'({wdata[7:4], wdata[3], wdata[2], wdata[0]});

  always_comb begin
    // Working register is one side, except for increment and decrement on the file register; literal or file register the other.
    src_a = st_q.working_register;
    src_b = ins.use_lit ? st_q.oper : st_q.file;
    if (ins.op == asf_pkg::ASF_OP_SUB) begin
      add_b = ~st_q.working_register;
      add_cin = 1'b1;
      src_a = src_b;
    end else if (ins.op == asf_pkg::ASF_OP_INC || ins.op == asf_pkg::ASF_OP_DEC) begin
      src_a = ins.single_on_file ? st_q.file : st_q.working_register;
      add_b = (ins.op == asf_pkg::ASF_OP_DEC) ? 8'hff : 8'h00;
      add_cin = (ins.op == asf_pkg::ASF_OP_INC);
    end else begin
      add_b = src_b;
      add_cin = 1'b0;
    end
  end

  asf_adder #(.WIDTH(8)) u_add (
    .a(src_a),
    .b(add_b),
    .cin(add_cin),
    .sum(sum),
    .half(half),
    .carry(carry),
    .ovf(ovf)
  );

  always_comb begin
    logic [7:0] res;
    logic [7:0] single;
    logic [7:0] st;
    logic fz;
    logic fh;
    logic fc;
    logic fo;
    res = 8'h00;
    single = ins.single_on_file ? st_q.file : st_q.working_register;
    st = st_q.status;
    fz = 1'b0;
    fh = 1'b0;
    fc = 1'b0;
    fo = 1'b0;
    st_d = st_q;
    st_d.rdata = 8'h00;
    if (rd_stb) begin
      case (addr)
        `ASF_STATUS_OFS: st_d.rdata = st_q.status;
        `ASF_INSTR_OFS: st_d.rdata = st_q.instr;
        `ASF_OPER_OFS: st_d.rdata = st_q.oper;
        `ASF_RESULT_OFS: st_d.rdata = st_q.result;
        `ASF_WORKING_REGISTER_OFS: st_d.rdata = st_q.working_register;
        `ASF_FILE_OFS: st_d.rdata = st_q.file;
        `ASF_PTR0_OFS: st_d.rdata = st_q.ptr0;
        `ASF_PTR1_OFS: st_d.rdata = st_q.ptr1;
        default: st_d.rdata = 8'h00;
      endcase
    end
    if (wr_stb) begin
      case (addr)
        `ASF_STATUS_OFS: st_d.status = wdata;
        `ASF_OPER_OFS: st_d.oper = wdata;
        `ASF_WORKING_REGISTER_OFS: st_d.working_register = wdata;
        `ASF_FILE_OFS: st_d.file = wdata;
        `ASF_PTR0_OFS: st_d.ptr0 = wdata;
        `ASF_PTR1_OFS: st_d.ptr1 = wdata;
        `ASF_INSTR_OFS: begin
          st_d.instr = wdata;
          case (asf_pkg::asf_op_e'(ins.op))
            asf_pkg::ASF_OP_ADD: begin
              res = sum;
              fh = half;
              fc = carry;
              fo = ovf;
              fz = (res == 8'h00);
              st = {st[7:4], fo, fz, fh, fc};
            end
            asf_pkg::ASF_OP_SUB: begin
              // Carry set means no borrow, so it is the raw adder carry.
              res = sum;
              st = {st[7:4], ovf, (res == 8'h00), half, carry};
            end
            asf_pkg::ASF_OP_INC, asf_pkg::ASF_OP_DEC: begin
              res = sum;
              st = {st[7:4], ovf, (res == 8'h00), half, carry};
            end
            asf_pkg::ASF_OP_AND: begin
              res = st_q.working_register & src_b;
              st[`ASF_ZERO_BIT] = (res == 8'h00);
            end
            asf_pkg::ASF_OP_IOR: begin
              res = st_q.working_register | src_b;
              st[`ASF_ZERO_BIT] = (res == 8'h00);
            end
            asf_pkg::ASF_OP_XOR: begin
              res = st_q.working_register ^ src_b;
              st[`ASF_ZERO_BIT] = (res == 8'h00);
            end
            asf_pkg::ASF_OP_COM: begin
              res = ~single;
              st[`ASF_ZERO_BIT] = (res == 8'h00);
            end
            asf_pkg::ASF_OP_RLC: begin
              res = {single[6:0], st_q.status[`ASF_CARRY_BIT]};
              st[`ASF_CARRY_BIT] = single[7];
            end
            asf_pkg::ASF_OP_RRC: begin
              res = {st_q.status[`ASF_CARRY_BIT], single[7:1]};
              st[`ASF_CARRY_BIT] = single[0];
            end
            asf_pkg::ASF_OP_CLR: begin
              res = 8'h00;
              st[`ASF_ZERO_BIT] = 1'b1;
            end
            asf_pkg::ASF_OP_MOV: begin
              res = src_b;
            end
            asf_pkg::ASF_OP_IND: begin
              st_d.ptr0 = ptr_step(st_q.ptr0, st_q.status[5:4]);
              st_d.ptr1 = ptr_step(st_q.ptr1, st_q.status[7:6]);
            end
            default: res = st_q.result;
          endcase
          // Codes past the last defined opcode must not fall through into a result write.
          if (ins.op >= asf_pkg::ASF_OP_ADD && ins.op <= asf_pkg::ASF_OP_MOV) begin
            st_d.result = res;
            st_d.status = st;
            if (ins.dest_file) begin
              if (ins.op == asf_pkg::ASF_OP_CLR) begin
                // Clearing the status register itself: modes zero, zero flag set.
                st_d.status = {4'h0, st_q.status[3], 1'b1, st_q.status[1:0]};
              end else if (ins.op == asf_pkg::ASF_OP_AND || ins.op == asf_pkg::ASF_OP_IOR ||
                           ins.op == asf_pkg::ASF_OP_XOR || ins.op == asf_pkg::ASF_OP_COM) begin
                st_d.status = {res[7:3], st[2], res[1:0]};
              end else if (ins.op == asf_pkg::ASF_OP_MOV) begin
                st_d.status = res;
              end else begin
                // Flag-setting instructions keep computed zero, half and carry.
                st_d.status = {res[7:3], st[2:0]};
              end
            end else if (ins.single_on_file) begin
              st_d.file = res;
            end else begin
              st_d.working_register = res;
            end
          end
        end
        default: st_d.status = st_q.status;
      endcase
    end
    if (srst) begin
      st_d = '0;
      st_d.status = `ASF_STATUS_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  assign rdata = st_q.rdata;
  assign arith_status_register = st_q.status;
  assign indirect_pointer_zero = st_q.ptr0;
  assign indirect_pointer_one = st_q.ptr1;

  sequence clr_issue_s;
    wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_CLR) && wdata[2];
  endsequence

  status_clear_a: assert property (@(posedge core_clk) disable iff (srst)
    clr_issue_s |=> arith_status_register[7:4] == 4'h0 && arith_status_register[2] &&
      arith_status_register[3] == $past(arith_status_register[3]) &&
      arith_status_register[1:0] == $past(arith_status_register[1:0]))
    else $error("status clear wrong");

  add_carry_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_ADD) && !wdata[2])
    |=> arith_status_register[0] == $past(carry))
    else $error("add carry wrong");

  half_carry_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_ADD))
    |=> arith_status_register[1] == $past(half))
    else $error("half carry wrong");

  zero_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_ADD) && !wdata[2])
    |=> arith_status_register[2] == (st_q.result == 8'h00))
    else $error("zero flag wrong");

  sub_borrow_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_SUB) && !wdata[2])
    |=> arith_status_register[0] == ($past(src_b) >= $past(st_q.working_register)))
    else $error("borrow sense wrong");

  signed_ovf_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_ADD) && !wdata[2])
    |=> arith_status_register[3] == (($signed({$past(st_q.working_register[7]), $past(st_q.working_register)}) +
      $signed({$past(src_b[7]), $past(src_b)})) > 9'sd127 ||
      ($signed({$past(st_q.working_register[7]), $past(st_q.working_register)}) +
      $signed({$past(src_b[7]), $past(src_b)})) < -9'sd128))
    else $error("overflow wrong");

  rot_left_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_RLC) && !wdata[2] &&
      !wdata[0]) |=> arith_status_register[0] == $past(st_q.working_register[7]))
    else $error("rotate carry wrong");

  ptr_mode_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_IND) &&
      arith_status_register[5:4] == `ASF_MODE_INC)
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) + 8'h01)
    else $error("pointer step wrong");

  read_data_a: assert property (@(posedge core_clk) disable iff (srst)
    (rd_stb && addr == `ASF_STATUS_OFS && !wr_stb) |=> rdata == $past(arith_status_register))
    else $error("read data wrong");

  rot_right_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_RRC) && !wdata[2] &&
      !wdata[0]) |=> arith_status_register[0] == $past(st_q.working_register[0]))
    else $error("rotate right carry wrong");

  flag_protect_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_ADD) && wdata[2])
    |=> arith_status_register[2:0] == {$past(sum) == 8'h00, $past(half), $past(carry)} &&
      arith_status_register[7:3] == $past(sum[7:3]))
    else $error("protected flags overwritten");

  sub_half_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_SUB) && !wdata[2])
    |=> arith_status_register[1] == ($past(src_b[3:0]) >= $past(st_q.working_register[3:0])))
    else $error("half borrow sense wrong");

  operand_pick_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_ADD) && !wdata[2])
    |=> st_q.result == 8'($past(st_q.working_register) + $past(wdata[3] ? st_q.oper : st_q.file)))
    else $error("operand source wrong");

  single_pick_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_COM) && !wdata[2] &&
      wdata[0]) |=> st_q.file == ~$past(st_q.file))
    else $error("single operand source wrong");

  sub_twos_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_SUB) && !wdata[2])
    |=> st_q.result == 8'($past(src_b) + ~$past(st_q.working_register) + 8'h01))
    else $error("subtraction result wrong");

  ptr_dec_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_IND) &&
      arith_status_register[7:6] == `ASF_MODE_DEC)
    |=> indirect_pointer_one == 8'($past(indirect_pointer_one) - 8'h01))
    else $error("pointer one step wrong");

  ptr_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_IND) &&
      arith_status_register[7]) |=> indirect_pointer_one == $past(indirect_pointer_one))
    else $error("pointer one hold wrong");

  refuse_op_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && (wdata[7:4] == 4'h0 ||
      wdata[7:4] > 4'(asf_pkg::ASF_OP_IND))) |=> st_q.working_register == $past(st_q.working_register) &&
      st_q.file == $past(st_q.file) && arith_status_register == $past(arith_status_register))
    else $error("refused opcode changed state");

  logic_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_AND) && !wdata[2])
    |=> arith_status_register[2] == (st_q.result == 8'h00) &&
      arith_status_register[3] == $past(arith_status_register[3]) &&
      arith_status_register[1:0] == $past(arith_status_register[1:0]))
    else $error("logic flags wrong");

  mov_status_a: assert property (@(posedge core_clk) disable iff (srst)
    (wr_stb && addr == `ASF_INSTR_OFS && wdata[7:4] == 4'(asf_pkg::ASF_OP_MOV) && wdata[2])
    |=> arith_status_register == $past(wdata[3] ? st_q.oper : st_q.file))
    else $error("status move wrong");
endmodule
`default_nettype wire

/* File: hdl/asf_pkg.sv */
// Purpose: Types of the arithmetic status block.
// Assumes: None.
// Notes: Opcodes are written to the instruction register.
package asf_pkg;
  typedef enum logic [3:0] {
    ASF_OP_NOP, ASF_OP_ADD, ASF_OP_SUB, ASF_OP_AND, ASF_OP_IOR, ASF_OP_XOR,
    ASF_OP_INC, ASF_OP_DEC, ASF_OP_COM, ASF_OP_RLC, ASF_OP_RRC, ASF_OP_CLR,
    ASF_OP_MOV, ASF_OP_IND
  } asf_op_e;
  typedef struct packed {
    logic [3:0] op;
    logic use_lit;
    logic dest_file;
    logic single_on_file;
  } asf_instr_s;
endpackage

/* File: testbench/alu_status_flags_tb.sv */
// Purpose: Self-checking bench for the arithmetic status and pointer mode block.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: Each scenario seeds status and operands, runs one instruction, then reads back.
`timescale 1ns/1ns
`default_nettype none
`include "asf_consts.svh"
module alu_status_flags_tb;
  logic core_clk;
  logic srst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata;
  logic [7:0] st;
  logic [7:0] p0;
  logic [7:0] p1;
  int bad_count;
  int n_checks;

  asf_core uut (
    .core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .arith_status_register(st),
    .indirect_pointer_zero(p0), .indirect_pointer_one(p1)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The write strobe is left high so back-to-back writes never assign it twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the taking edge, so they are sampled mid-cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(negedge core_clk);
    chk(rdata, exp);
    @(posedge core_clk);
  endtask

  // Selector bits are use literal, status destination, unused, single operand on file.
  task automatic exec(input logic [3:0] op, input logic [3:0] sel, input logic [7:0] w,
      input logic [7:0] src, input logic [7:0] pre, input logic [7:0] res,
      input logic [7:0] sts);
    wr(`ASF_STATUS_OFS, pre);
    wr(`ASF_WORKING_REGISTER_OFS, w);
    wr(sel[3] ? `ASF_OPER_OFS : `ASF_FILE_OFS, src);
    wr(`ASF_INSTR_OFS, {op, sel});
    rd_chk(sel[2] ? `ASF_STATUS_OFS : (sel[0] ? `ASF_FILE_OFS : `ASF_RESULT_OFS), res);
    rd_chk(`ASF_STATUS_OFS, sts);
    chk(st, sts);
  endtask

  task automatic ptr_case(input logic [7:0] mode, input logic [7:0] e0, input logic [7:0] e1);
    wr(`ASF_PTR0_OFS, 8'h10);
    wr(`ASF_PTR1_OFS, 8'h20);
    wr(`ASF_STATUS_OFS, mode);
    wr(`ASF_INSTR_OFS, {asf_pkg::ASF_OP_IND, 4'h0});
    rd_chk(`ASF_PTR0_OFS, e0);
    rd_chk(`ASF_PTR1_OFS, e1);
    chk(p0, e0);
    chk(p1, e1);
  endtask

  // Undefined codes and the empty opcode must leave working register and status alone.
  task automatic refuse_case(input logic [3:0] op);
    wr(`ASF_STATUS_OFS, 8'ha5);
    wr(`ASF_WORKING_REGISTER_OFS, 8'h12);
    wr(`ASF_INSTR_OFS, {op, 4'h0});
    rd_chk(`ASF_WORKING_REGISTER_OFS, 8'h12);
    rd_chk(`ASF_STATUS_OFS, 8'ha5);
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // About 200 cycles of traffic are expected; the limit leaves a wide margin.
  initial begin
    #20000;
    bad_count++;
    test_done();
  end

  initial begin
    bad_count = 0;
    n_checks = 0;
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(`ASF_STATUS_OFS, `ASF_STATUS_RST);
    chk(st, `ASF_STATUS_RST);
    chk(p0, 8'h00);
    chk(p1, 8'h00);
    wr(8'h3f, 8'h55);
    rd_chk(8'h3f, 8'h00);
    rd_chk(`ASF_STATUS_OFS, `ASF_STATUS_RST);
    exec(asf_pkg::ASF_OP_ADD, 4'h0, 8'h0f, 8'h01, 8'h00, 8'h10, 8'h02);
    exec(asf_pkg::ASF_OP_ADD, 4'h8, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h0a);
    exec(asf_pkg::ASF_OP_ADD, 4'h8, 8'hff, 8'h01, 8'h00, 8'h00, 8'h07);
    exec(asf_pkg::ASF_OP_SUB, 4'h8, 8'h05, 8'h03, 8'h03, 8'hfe, 8'h00);
    exec(asf_pkg::ASF_OP_SUB, 4'h8, 8'h03, 8'h05, 8'h00, 8'h02, 8'h03);
    exec(asf_pkg::ASF_OP_SUB, 4'h8, 8'h01, 8'h80, 8'h00, 8'h7f, 8'h09);
    exec(asf_pkg::ASF_OP_AND, 4'h0, 8'h0f, 8'hf0, 8'h03, 8'h00, 8'h07);
    exec(asf_pkg::ASF_OP_IOR, 4'h0, 8'h0f, 8'hf0, 8'h04, 8'hff, 8'h00);
    exec(asf_pkg::ASF_OP_XOR, 4'h8, 8'hff, 8'hff, 8'h00, 8'h00, 8'h04);
    exec(asf_pkg::ASF_OP_RLC, 4'h0, 8'h81, 8'h00, 8'h00, 8'h02, 8'h01);
    exec(asf_pkg::ASF_OP_RRC, 4'h0, 8'h02, 8'h00, 8'h05, 8'h81, 8'h04);
    exec(asf_pkg::ASF_OP_INC, 4'h1, 8'h00, 8'hff, 8'h00, 8'h00, 8'h07);
    exec(asf_pkg::ASF_OP_DEC, 4'h0, 8'h80, 8'h00, 8'h00, 8'h7f, 8'h09);
    exec(asf_pkg::ASF_OP_COM, 4'h1, 8'h00, 8'hff, 8'h00, 8'h00, 8'h04);
    exec(asf_pkg::ASF_OP_ADD, 4'hc, 8'hf0, 8'h0f, 8'h00, 8'hf8, 8'hf8);
    exec(asf_pkg::ASF_OP_COM, 4'h4, 8'hff, 8'h00, 8'h03, 8'h04, 8'h04);
    exec(asf_pkg::ASF_OP_MOV, 4'hc, 8'h00, 8'ha5, 8'h00, 8'ha5, 8'ha5);
    exec(asf_pkg::ASF_OP_CLR, 4'h4, 8'h00, 8'h00, 8'hfb, 8'h0f, 8'h0f);
    refuse_case(4'h0);
    refuse_case(4'hf);
    ptr_case(8'h10, 8'h11, 8'h1f);
    ptr_case(8'h40, 8'h0f, 8'h21);
    ptr_case(8'ha0, 8'h10, 8'h20);
    ptr_case(8'hf0, 8'h10, 8'h20);
    test_done();
  end
endmodule
`default_nettype wire
